/* hw/odc_params.svh */
`ifndef ODC_PARAMS_SVH
`define ODC_PARAMS_SVH
`define ODC_ADDR_OFFSET_CFG 8'h3A
`define ODC_ADDR_DEC_CTRL 8'h3D
`define ODC_ADDR_AVG_LED2 8'h3F
`define ODC_ADDR_AVG_LED1 8'h40
`define ODC_SIGN_LED2_BIT 19
`define ODC_MAG_LED2_HI 18
`define ODC_MAG_LED2_LO 15
`define ODC_SIGN_AMB1_BIT 14
`define ODC_MAG_AMB1_HI 13
`define ODC_MAG_AMB1_LO 10
`define ODC_SIGN_LED1_BIT 9
`define ODC_MAG_LED1_HI 8
`define ODC_MAG_LED1_LO 5
`define ODC_SIGN_PH4_BIT 4
`define ODC_MAG_PH4_HI 3
`define ODC_MAG_PH4_LO 0
`define ODC_OFFSET_CFG_MASK 24'h0FFFFF
`define ODC_AVG_ENABLE_BIT 5
`define ODC_AVG_SEL_HI 3
`define ODC_AVG_SEL_LO 1
`define ODC_DEC_CTRL_MASK 24'h00002E
`define ODC_AVG_SEL_MAX 3'h4
`define ODC_RESET_VALUE 24'h000000
`endif

/* hw/odc_pkg.sv */
package odc_pkg;
   typedef logic [23:0] odc_word_type;
   typedef logic [3:0] odc_mag_type;
   typedef enum logic [1:0]
   {
      ODC_ACC_IDLE = 2'h1,
      ODC_ACC_RUN = 2'h2
   } odc_acc_state_type;
endpackage

/* hw/odc_offset_dac_decimation_cfg.sv */
`timescale 1ns/1ps
`include "odc_params.svh"
module odc_offset_dac_decimation_cfg
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [7:0] reg_addr,
   input wire odc_pkg::odc_word_type wr_data,
   output odc_pkg::odc_word_type rd_data,
   output logic rd_valid,
   input wire logic sample_valid,
   input wire odc_pkg::odc_word_type sample_led2,
   input wire odc_pkg::odc_word_type sample_led1,
   output odc_pkg::odc_mag_type offset_magnitude_phase_led2,
   output logic offset_sign_phase_led2,
   output odc_pkg::odc_mag_type offset_magnitude_ambient_one,
   output logic offset_sign_ambient_one,
   output odc_pkg::odc_mag_type offset_magnitude_phase_led1,
   output logic offset_sign_phase_led1,
   output odc_pkg::odc_mag_type offset_magnitude_fourth_phase,
   output logic offset_sign_fourth_phase,
   output logic averaging_enable,
   output logic [2:0] averaging_count_select,
   output logic result_update
);
   import odc_pkg::*;

   odc_word_type offset_cfg_r;
   odc_word_type dec_ctrl_r;
   odc_word_type avg_led2_r;
   odc_word_type avg_led1_r;
   logic signed [27:0] acc_led2_r;
   logic signed [27:0] acc_led1_r;
   logic [4:0] acc_cnt_r;
   odc_acc_state_type state_r;
   odc_acc_state_type state_nxt;

   // selected field names; each magnitude/sign pair serves one phase
   wire [3:0] mag_led2_w = offset_cfg_r[`ODC_MAG_LED2_HI:`ODC_MAG_LED2_LO];
   wire sign_led2_w = offset_cfg_r[`ODC_SIGN_LED2_BIT];
   wire [3:0] mag_amb1_w = offset_cfg_r[`ODC_MAG_AMB1_HI:`ODC_MAG_AMB1_LO];
   wire sign_amb1_w = offset_cfg_r[`ODC_SIGN_AMB1_BIT];
   wire [3:0] mag_led1_w = offset_cfg_r[`ODC_MAG_LED1_HI:`ODC_MAG_LED1_LO];
   wire sign_led1_w = offset_cfg_r[`ODC_SIGN_LED1_BIT];
   wire [3:0] mag_ph4_w = offset_cfg_r[`ODC_MAG_PH4_HI:`ODC_MAG_PH4_LO];
   wire sign_ph4_w = offset_cfg_r[`ODC_SIGN_PH4_BIT];
   wire averaging_on_w = dec_ctrl_r[`ODC_AVG_ENABLE_BIT];
   wire [2:0] count_sel_w = dec_ctrl_r[`ODC_AVG_SEL_HI:`ODC_AVG_SEL_LO];
   // host must keep factor at 4 or below; higher codes are clamped to 16 samples
   wire [2:0] shift_w = (count_sel_w > `ODC_AVG_SEL_MAX) ? `ODC_AVG_SEL_MAX : count_sel_w;
   wire [4:0] group_len_w = 5'(5'h01 << shift_w);

   wire wr_cfg_w = wr_en && (reg_addr == `ODC_ADDR_OFFSET_CFG);
   wire wr_dec_w = wr_en && (reg_addr == `ODC_ADDR_DEC_CTRL);
   wire cfg_change_w = wr_dec_w;

   wire signed [27:0] sum_led2_w = acc_led2_r + 28'(signed'(sample_led2));
   wire signed [27:0] sum_led1_w = acc_led1_r + 28'(signed'(sample_led1));
   // a control write in the closing cycle drops the group, so no pulse without a store
   wire last_w = (state_r == ODC_ACC_RUN) && averaging_on_w && !cfg_change_w && sample_valid
      && (acc_cnt_r + 5'h01 == group_len_w);
   // arithmetic shift keeps the two's-complement sign of the average
   wire signed [27:0] avg2_full_w = sum_led2_w >>> shift_w;
   wire signed [27:0] avg1_full_w = sum_led1_w >>> shift_w;

   odc_word_type rd_mux_w;
   assign rd_mux_w = (reg_addr == `ODC_ADDR_OFFSET_CFG) ? offset_cfg_r :
                     (reg_addr == `ODC_ADDR_DEC_CTRL) ? dec_ctrl_r :
                     (reg_addr == `ODC_ADDR_AVG_LED2) ? avg_led2_r :
                     (reg_addr == `ODC_ADDR_AVG_LED1) ? avg_led1_r :
                     `ODC_RESET_VALUE;

   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         ODC_ACC_IDLE: if (averaging_on_w && !cfg_change_w) state_nxt = ODC_ACC_RUN;
         ODC_ACC_RUN: if (!averaging_on_w || cfg_change_w) state_nxt = ODC_ACC_IDLE;
         default: state_nxt = ODC_ACC_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         offset_cfg_r <= `ODC_RESET_VALUE;
         dec_ctrl_r <= `ODC_RESET_VALUE;
      end
      else
      begin
         // reserved bits must be written zero and read back zero
         if (wr_cfg_w) offset_cfg_r <= wr_data & `ODC_OFFSET_CFG_MASK;
         if (wr_dec_w) dec_ctrl_r <= wr_data & `ODC_DEC_CTRL_MASK;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         state_r <= ODC_ACC_IDLE;
         acc_led2_r <= '0;
         acc_led1_r <= '0;
         acc_cnt_r <= 5'h00;
         avg_led2_r <= `ODC_RESET_VALUE;
         avg_led1_r <= `ODC_RESET_VALUE;
         result_update <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         result_update <= last_w;
         // a config change restarts the group so no mixed-length average escapes
         if (state_r != ODC_ACC_RUN || cfg_change_w || !averaging_on_w)
         begin
            acc_led2_r <= '0;
            acc_led1_r <= '0;
            acc_cnt_r <= 5'h00;
         end
         else if (last_w)
         begin
            avg_led2_r <= avg2_full_w[23:0];
            avg_led1_r <= avg1_full_w[23:0];
            acc_led2_r <= '0;
            acc_led1_r <= '0;
            acc_cnt_r <= 5'h00;
         end
         else if (sample_valid)
         begin
            acc_led2_r <= sum_led2_w;
            acc_led1_r <= sum_led1_w;
            acc_cnt_r <= acc_cnt_r + 5'h01;
         end
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         rd_data <= `ODC_RESET_VALUE;
         rd_valid <= 1'b0;
         offset_magnitude_phase_led2 <= 4'h0;
         offset_sign_phase_led2 <= 1'b0;
         offset_magnitude_ambient_one <= 4'h0;
         offset_sign_ambient_one <= 1'b0;
         offset_magnitude_phase_led1 <= 4'h0;
         offset_sign_phase_led1 <= 1'b0;
         offset_magnitude_fourth_phase <= 4'h0;
         offset_sign_fourth_phase <= 1'b0;
         averaging_enable <= 1'b0;
         averaging_count_select <= 3'h0;
      end
      else
      begin
         rd_data <= rd_en ? rd_mux_w : rd_data;
         rd_valid <= rd_en;
         // analog side scales code linearly, sign bit negates
         offset_magnitude_phase_led2 <= mag_led2_w;
         offset_sign_phase_led2 <= sign_led2_w;
         offset_magnitude_ambient_one <= mag_amb1_w;
         offset_sign_ambient_one <= sign_amb1_w;
         offset_magnitude_phase_led1 <= mag_led1_w;
         offset_sign_phase_led1 <= sign_led1_w;
         offset_magnitude_fourth_phase <= mag_ph4_w;
         offset_sign_fourth_phase <= sign_ph4_w;
         averaging_enable <= averaging_on_w;
         averaging_count_select <= count_sel_w;
      end
   end

   chk_cfg_write_lands: assert property (@(posedge ref_clk) disable iff (reset)
      wr_cfg_w |=> ##1 offset_magnitude_phase_led2 == $past(wr_data[18:15], 2))
      else $error("led2 magnitude not applied");
   chk_sign_follows: assert property (@(posedge ref_clk) disable iff (reset)
      wr_cfg_w |=> ##1 offset_sign_phase_led2 == $past(wr_data[19], 2))
      else $error("led2 sign not applied");
   chk_ph4_follows: assert property (@(posedge ref_clk) disable iff (reset)
      wr_cfg_w |=> ##1 offset_magnitude_fourth_phase == $past(wr_data[3:0], 2))
      else $error("fourth phase magnitude wrong");
   chk_amb1_follows: assert property (@(posedge ref_clk) disable iff (reset)
      wr_cfg_w |=> ##1 offset_magnitude_ambient_one == $past(wr_data[13:10], 2))
      else $error("ambient one magnitude wrong");
   chk_en_follows: assert property (@(posedge ref_clk) disable iff (reset)
      wr_dec_w |=> ##1 averaging_enable == $past(wr_data[5], 2))
      else $error("averaging enable wrong");
   chk_no_update_off: assert property (@(posedge ref_clk) disable iff (reset)
      !averaging_on_w |=> ##1 !result_update)
      else $error("result updated while disabled");
   chk_result_holds: assert property (@(posedge ref_clk) disable iff (reset)
      !last_w |=> $stable(avg_led2_r) && $stable(avg_led1_r))
      else $error("average changed mid group");
   chk_count_bound: assert property (@(posedge ref_clk) disable iff (reset)
      acc_cnt_r < group_len_w)
      else $error("group count overran");
   chk_read_back: assert property (@(posedge ref_clk) disable iff (reset)
      rd_en && reg_addr == `ODC_ADDR_AVG_LED2 && !last_w |=> rd_data == avg_led2_r && rd_valid)
      else $error("led2 average read mismatch");

   cov_update: cover property (@(posedge ref_clk) disable iff (reset) result_update);
   cov_sixteen: cover property (@(posedge ref_clk) disable iff (reset) last_w && shift_w == 3'h4);
   cov_single: cover property (@(posedge ref_clk) disable iff (reset) last_w && shift_w == 3'h0);
   cov_restart: cover property (@(posedge ref_clk) disable iff (reset) state_r == ODC_ACC_RUN && cfg_change_w);
endmodule // odc_offset_dac_decimation_cfg

/* tb/odc_offset_dac_decimation_cfg_tb_top.sv */
`timescale 1ns/1ps
`include "odc_params.svh"
module odc_offset_dac_decimation_cfg_tb_top;
   import odc_pkg::*;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   odc_word_type wr_data = 24'h000000;
   odc_word_type rd_data;
   logic rd_valid;
   logic sample_valid = 1'b0;
   odc_word_type sample_led2 = 24'h000000;
   odc_word_type sample_led1 = 24'h000000;
   odc_mag_type m_l2, m_a1, m_l1, m_p4;
   logic s_l2, s_a1, s_l1, s_p4, avg_en, upd;
   logic [2:0] cnt_sel;
   int n_errors = 0;
   int checks_done = 0;
   int k;
   logic signed [28:0] sum2, sum1;
   odc_word_type e2, e1;
   odc_word_type pats [10] = '{24'hFFFFFF, 24'h080000, 24'h078000, 24'h004000, 24'h003C00,
      24'h000200, 24'h0001E0, 24'h000010, 24'h00000F, 24'h05A5A5};
   // packed in register bit order so one compare covers every field position
   wire odc_word_type cfg_out = {4'h0, s_l2, m_l2, s_a1, m_a1, s_l1, m_l1, s_p4, m_p4};
   wire odc_word_type dec_out = {20'h0, avg_en, cnt_sel};
   always #10 ref_clk = ~ref_clk;
   odc_offset_dac_decimation_cfg u_dut
   (
      .ref_clk(ref_clk), .reset(reset), .wr_en(wr_en), .rd_en(rd_en), .reg_addr(reg_addr),
      .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid), .sample_valid(sample_valid),
      .sample_led2(sample_led2), .sample_led1(sample_led1),
      .offset_magnitude_phase_led2(m_l2), .offset_sign_phase_led2(s_l2),
      .offset_magnitude_ambient_one(m_a1), .offset_sign_ambient_one(s_a1),
      .offset_magnitude_phase_led1(m_l1), .offset_sign_phase_led1(s_l1),
      .offset_magnitude_fourth_phase(m_p4), .offset_sign_fourth_phase(s_p4),
      .averaging_enable(avg_en), .averaging_count_select(cnt_sel), .result_update(upd)
   );
   task automatic chk(input odc_word_type got, input odc_word_type exp);
      checks_done++;
      if (got !== exp)
      begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // extra idle edge lets the config outputs and the enable state settle
   task automatic wr(input logic [7:0] a, input odc_word_type d);
      @(negedge ref_clk);
      wr_en = 1'b1;
      reg_addr = a;
      wr_data = d;
      @(negedge ref_clk);
      wr_en = 1'b0;
      @(negedge ref_clk);
   endtask
   task automatic rd(input logic [7:0] a, input odc_word_type exp);
      @(negedge ref_clk);
      rd_en = 1'b1;
      reg_addr = a;
      @(negedge ref_clk);
      rd_en = 1'b0;
      chk({23'h0, rd_valid}, 24'h000001);
      chk(rd_data, exp);
   endtask
   // leaves sample_valid high so samples run back to back
   task automatic smp(input int i);
      @(negedge ref_clk);
      sample_valid = 1'b1;
      sample_led2 = 24'(i * 37 - 100);
      sample_led1 = 24'(-(i * i) - 3);
      sum2 = sum2 + 29'($signed(sample_led2));
      sum1 = sum1 + 29'($signed(sample_led1));
   endtask
   task automatic end_of_test;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial
   begin
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      reset = 1'b0;
      chk(cfg_out, 24'h000000);
      rd(`ODC_ADDR_OFFSET_CFG, 24'h000000);
      rd(`ODC_ADDR_DEC_CTRL, 24'h000000);
      rd(`ODC_ADDR_AVG_LED2, 24'h000000);
      rd(`ODC_ADDR_AVG_LED1, 24'h000000);
      foreach (pats[j])
      begin
         wr(`ODC_ADDR_OFFSET_CFG, pats[j]);
         chk(cfg_out, pats[j] & 24'h0FFFFF);
         rd(`ODC_ADDR_OFFSET_CFG, pats[j] & 24'h0FFFFF);
      end
      wr(8'h3B, 24'hFFFFFF);
      rd(8'h3B, 24'h000000);
      wr(`ODC_ADDR_AVG_LED2, 24'h123456);
      rd(`ODC_ADDR_AVG_LED2, 24'h000000);
      // reserved bits all set, but the count code stays one the host may write
      wr(`ODC_ADDR_DEC_CTRL, 24'hFFFFF9);
      rd(`ODC_ADDR_DEC_CTRL, 24'h000028);
      chk(dec_out, 24'h00000C);
      for (int f = 0; f <= 4; f++)
      begin
         wr(`ODC_ADDR_DEC_CTRL, 24'h000020 | 24'(f << 1));
         chk(dec_out, 24'(8 + f));
         sum2 = '0;
         sum1 = '0;
         for (int i = 0; i < (1 << f); i++)
            smp(i + f);
         e2 = 24'(sum2 >>> f);
         e1 = 24'(sum1 >>> f);
         @(negedge ref_clk);
         sample_valid = 1'b0;
         k = 0;
         while (upd !== 1'b1 && k < 5)
         begin
            @(negedge ref_clk);
            k++;
         end
         chk({23'h0, upd}, 24'h000001);
         rd(`ODC_ADDR_AVG_LED2, e2);
         rd(`ODC_ADDR_AVG_LED1, e1);
         if (f > 0)
         begin
            smp(99);
            @(negedge ref_clk);
            sample_valid = 1'b0;
            rd(`ODC_ADDR_AVG_LED2, e2);
         end
      end
      wr(`ODC_ADDR_DEC_CTRL, 24'h000000);
      chk(dec_out, 24'h000000);
      repeat (3) smp(7);
      @(negedge ref_clk);
      sample_valid = 1'b0;
      rd(`ODC_ADDR_AVG_LED1, e1);
      end_of_test();
   end
   // whole sequence needs well under a thousand cycles
   initial
   begin
      #200000;
      n_errors++;
      end_of_test();
   end
endmodule // odc_offset_dac_decimation_cfg_tb_top
